// file: src/hrp_pkg.sv
// constants and types of the host register port
//
// Function
// - one shared 16-bit three-state data bus carries a whole register word
// - async active-low reset idles port, clears writable and clear-on-read registers
// - reads change nothing except clearing event register and three counters
// - cycle starts on edge sampling select asserted; address and direction captured
// - read drive starts at least half a cycle after starting edge
// - read data valid after second rising edge following select assertion
// - data held until second edge after select release, then floated
// - select sampled from second edge on; each asserted sample reloads the two-edge hold
// - one access per select assertion; select must release between accesses
// - illegal write sets access-error flag and leaves register unchanged
`default_nettype none

package hrp_pkg;

	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 5;
	localparam int NUM_CFG    = 16;
	localparam int NUM_STAT   = 7;
	localparam int NUM_CNT    = 3;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL_A      = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_VECTOR      = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_VECTOR_LEN  = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_TPC_LOAD    = 5'h0E;
	localparam logic [ADDR_W-1:0] ADDR_TNE_LOAD    = 5'h0F;
	localparam logic [ADDR_W-1:0] ADDR_STAT_FIRST  = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_EVENT       = 5'h17;
	localparam logic [ADDR_W-1:0] ADDR_CNT_FIRST   = 5'h18;
	localparam logic [ADDR_W-1:0] ADDR_LAST        = 5'h1A;

	// field positions
	localparam int NOISE_TIMER_BIT = 14;
	localparam int ACCESS_ERR_BIT  = 0;

	// reset and constant values
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] WORD_MAX  = 16'hFFFF;
	localparam logic [DATA_W-1:0] WORD_ONE  = 16'h0001;

	// timing: edges data is held after the last asserted select sample
	localparam logic [1:0] HOLD_EDGES   = 2'h2;
	localparam logic [1:0] HOLD_ONE     = 2'h1;
	localparam logic [1:0] HOLD_NONE    = 2'h0;
	localparam int         RST_MIN_CYC  = 20;

	// port state machine, gray along idle-wait-drive
	typedef enum logic [1:0] {
		ST_NOT_ACTIVE = 2'h0,
		ST_READ_WAIT  = 2'h1,
		ST_READ_DRIVE = 2'h3,
		ST_WRITE_WAIT = 2'h2
	} hrp_state_t;

endpackage : hrp_pkg

`default_nettype wire

// file: src/hrp_bus_fsm.sv
// host bus cycle sequencer: select sampling, turnaround, hold, strobes
`default_nettype none
`timescale 1ns/1ps

module hrp_bus_fsm
	import hrp_pkg::*;
(
	// clock and reset
	input  wire logic              mclk_i,
	input  wire logic              resetn_i,
	input  wire logic              ce_i,
	// host pins
	input  wire logic              host_cs_n_i,
	input  wire logic              host_direction_i,
	input  wire logic [ADDR_W-1:0] register_select_lines_i,
	input  wire logic [DATA_W-1:0] host_data_bus_i,
	output logic      [DATA_W-1:0] host_data_bus_o,
	output logic                   host_data_bus_oe_o,
	// register bank side
	input  wire logic [DATA_W-1:0] rd_data_i,
	output logic      [ADDR_W-1:0] acc_addr_o,
	output logic                   rd_stb_o,
	output logic                   wr_stb_o,
	output logic      [DATA_W-1:0] wr_data_o
);

	typedef struct packed {
		hrp_state_t        state;
		logic              armed;
		logic [ADDR_W-1:0] addr;
		logic [1:0]        rem;
		logic [DATA_W-1:0] dout;
		logic              oe;
	} hrp_fsm_t;

	hrp_fsm_t fsm_r;
	hrp_fsm_t fsm_nxt;
	logic     cs_on;
	logic     rd_stb;
	logic     wr_stb;

	assign cs_on = ~host_cs_n_i;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		fsm_nxt = fsm_r;
		rd_stb  = 1'b0;
		wr_stb  = 1'b0;
		if (!cs_on)
			fsm_nxt.armed = 1'b1;
		case (fsm_r.state)
			ST_NOT_ACTIVE:
			begin
				if (cs_on && fsm_r.armed)
				begin
					fsm_nxt.addr  = register_select_lines_i;
					fsm_nxt.armed = 1'b0;
					fsm_nxt.rem   = HOLD_EDGES;
					fsm_nxt.state = host_direction_i ? ST_READ_WAIT : ST_WRITE_WAIT;
				end
			end
			ST_READ_WAIT:
			begin
				// drive begins a full cycle after the start edge
				rd_stb       = 1'b1;
				fsm_nxt.dout = rd_data_i;
				fsm_nxt.oe   = 1'b1;
				fsm_nxt.rem  = cs_on ? HOLD_EDGES : HOLD_ONE;
				fsm_nxt.state = ST_READ_DRIVE;
			end
			ST_READ_DRIVE:
			begin
				if (cs_on)
					fsm_nxt.rem = HOLD_EDGES;
				else
					fsm_nxt.rem = fsm_r.rem - HOLD_ONE;
				if (!cs_on && fsm_r.rem == HOLD_ONE)
				begin
					fsm_nxt.oe    = 1'b0;
					fsm_nxt.rem   = HOLD_NONE;
					fsm_nxt.state = ST_NOT_ACTIVE;
				end
			end
			ST_WRITE_WAIT:
			begin
				// data sampled on the second edge, select release ignored
				wr_stb        = 1'b1;
				fsm_nxt.state = ST_NOT_ACTIVE;
			end
			default:
			begin
				fsm_nxt.state = ST_NOT_ACTIVE;
				fsm_nxt.oe    = 1'b0;
			end
		endcase
		if (!ce_i)
		begin
			fsm_nxt = fsm_r;
			rd_stb  = 1'b0;
			wr_stb  = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fsm_r.state <= ST_NOT_ACTIVE;
			fsm_r.armed <= 1'b0;
			fsm_r.addr  <= '0;
			fsm_r.rem   <= HOLD_NONE;
			fsm_r.dout  <= WORD_ZERO;
			fsm_r.oe    <= 1'b0;
		end
		else
			fsm_r <= fsm_nxt;
	end

	assign host_data_bus_o    = fsm_r.dout;
	assign host_data_bus_oe_o = fsm_r.oe;
	assign acc_addr_o         = fsm_r.addr;
	assign rd_stb_o           = rd_stb;
	assign wr_stb_o           = wr_stb;
	assign wr_data_o          = host_data_bus_i;

endmodule : hrp_bus_fsm

`default_nettype wire

// file: src/hrp_host_register_port.sv
// host register port: bus sequencer plus register bank and clear-on-read state
`default_nettype none
`timescale 1ns/1ps

module hrp_host_register_port
	import hrp_pkg::*;
(
	// clock, reset, enable
	input  wire logic                       mclk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       ce_i,
	// host pins
	input  wire logic                       host_cs_n_i,
	input  wire logic                       host_direction_i,
	input  wire logic [ADDR_W-1:0]          register_select_lines_i,
	input  wire logic [DATA_W-1:0]          host_data_bus_i,
	output logic      [DATA_W-1:0]          host_data_bus_o,
	output logic                            host_data_bus_oe_o,
	// core conditions for restricted writes
	input  wire logic                       pcm_signaling_i,
	input  wire logic                       pcm_maint_i,
	// core status words, read-only registers 10h..16h
	input  wire logic [NUM_STAT*DATA_W-1:0] status_words_i,
	// core events and counter increments
	input  wire logic [DATA_W-1:0]          event_set_i,
	input  wire logic [NUM_CNT-1:0]         count_inc_i,
	// register contents to the core
	output logic      [NUM_CFG*DATA_W-1:0]  cfg_words_o,
	output logic      [DATA_W-1:0]          event_register_o,
	output logic      [DATA_W-1:0]          violation_symbol_count_o,
	output logic      [DATA_W-1:0]          short_gap_count_o,
	output logic      [DATA_W-1:0]          link_error_count_o,
	output logic                            host_access_error_o
);

	typedef struct packed {
		logic [NUM_CFG-1:0][DATA_W-1:0] cfg;
		logic [DATA_W-1:0]              evt;
		logic [NUM_CNT-1:0][DATA_W-1:0] cnt;
		logic                           err;
	} hrp_bank_t;

	hrp_bank_t         bank_r;
	hrp_bank_t         bank_nxt;
	logic [ADDR_W-1:0] acc_addr;
	logic              rd_stb;
	logic              wr_stb;
	logic [DATA_W-1:0] wr_data;
	logic [DATA_W-1:0] rd_data;
	logic              wr_legal;
	logic [DATA_W-1:0] evt_clr;
	logic [NUM_CNT-1:0] cnt_clr;
	logic              is_cfg;
	logic              is_stat;
	logic              is_cnt;
	logic [ADDR_W-1:0] stat_idx;
	logic [ADDR_W-1:0] cnt_idx;

	////////////////////////////////////////////////////////////////////////////
	hrp_bus_fsm u_fsm (
		.mclk_i                  (mclk_i),
		.resetn_i                (resetn_i),
		.ce_i                    (ce_i),
		.host_cs_n_i             (host_cs_n_i),
		.host_direction_i        (host_direction_i),
		.register_select_lines_i (register_select_lines_i),
		.host_data_bus_i         (host_data_bus_i),
		.host_data_bus_o         (host_data_bus_o),
		.host_data_bus_oe_o      (host_data_bus_oe_o),
		.rd_data_i               (rd_data),
		.acc_addr_o              (acc_addr),
		.rd_stb_o                (rd_stb),
		.wr_stb_o                (wr_stb),
		.wr_data_o               (wr_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// address decode
	assign is_cfg   = (acc_addr < ADDR_STAT_FIRST);
	assign is_stat  = (acc_addr >= ADDR_STAT_FIRST) && (acc_addr < ADDR_EVENT);
	assign is_cnt   = (acc_addr >= ADDR_CNT_FIRST) && (acc_addr <= ADDR_LAST);
	assign stat_idx = acc_addr - ADDR_STAT_FIRST;
	assign cnt_idx  = acc_addr - ADDR_CNT_FIRST;

	// write permission
	always_comb
	begin
		wr_legal = is_cfg;
		if (acc_addr == ADDR_VECTOR || acc_addr == ADDR_VECTOR_LEN)
			wr_legal = ~pcm_signaling_i;
		else if (acc_addr == ADDR_TPC_LOAD)
			wr_legal = pcm_maint_i;
		else if (acc_addr == ADDR_TNE_LOAD)
			wr_legal = pcm_maint_i & ~bank_r.cfg[ADDR_CTRL_A[3:0]][NOISE_TIMER_BIT];
	end

	// read mux; write-only and unmapped addresses read zero
	always_comb
	begin
		rd_data = WORD_ZERO;
		if (is_cfg && acc_addr != ADDR_TPC_LOAD && acc_addr != ADDR_TNE_LOAD)
			rd_data = bank_r.cfg[acc_addr[3:0]];
		else if (is_stat)
			rd_data = status_words_i[stat_idx[2:0]*DATA_W +: DATA_W];
		else if (acc_addr == ADDR_EVENT)
			rd_data = bank_r.evt;
		else if (is_cnt)
			rd_data = bank_r.cnt[cnt_idx[1:0]];
	end

	////////////////////////////////////////////////////////////////////////////
	// clear-on-read strobes
	always_comb
	begin
		evt_clr = WORD_ZERO;
		if (rd_stb && acc_addr == ADDR_EVENT)
			evt_clr = WORD_MAX;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CNT; gi++)
		begin : g_cnt_clr
			assign cnt_clr[gi] = rd_stb && is_cnt && (cnt_idx == ADDR_W'(gi));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		bank_nxt     = bank_r;
		bank_nxt.err = 1'b0;
		// event bits: a set in the clearing cycle survives
		bank_nxt.evt = (bank_r.evt & ~evt_clr) | event_set_i;
		if (wr_stb && !wr_legal)
		begin
			bank_nxt.evt[ACCESS_ERR_BIT] = 1'b1;
			bank_nxt.err                 = 1'b1;
		end
		if (wr_stb && wr_legal)
			bank_nxt.cfg[acc_addr[3:0]] = wr_data;
		// counters saturate; an increment in the clearing cycle counts one
		for (int i = 0; i < NUM_CNT; i++)
		begin
			if (cnt_clr[i])
				bank_nxt.cnt[i] = count_inc_i[i] ? WORD_ONE : WORD_ZERO;
			else if (count_inc_i[i] && bank_r.cnt[i] != WORD_MAX)
				bank_nxt.cnt[i] = bank_r.cnt[i] + WORD_ONE;
		end
		if (!ce_i)
			bank_nxt = bank_r;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			bank_r <= '0;
		else
			bank_r <= bank_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	assign cfg_words_o              = bank_r.cfg;
	assign event_register_o         = bank_r.evt;
	assign violation_symbol_count_o = bank_r.cnt[0];
	assign short_gap_count_o        = bank_r.cnt[1];
	assign link_error_count_o       = bank_r.cnt[2];
	assign host_access_error_o      = bank_r.err;

endmodule : hrp_host_register_port

`default_nettype wire

// file: testbench/hrp_port_sva.sv
// checker for the host register port pins
`default_nettype none
`timescale 1ns/1ps
module hrp_port_sva
	import hrp_pkg::*;
(
	// watched pins
	input wire logic               mclk_i,
	input wire logic               resetn_i,
	input wire logic               host_cs_n_i,
	input wire logic               host_direction_i,
	input wire logic [ADDR_W-1:0]  register_select_lines_i,
	input wire logic [NUM_CNT-1:0] count_inc_i,
	input wire logic [DATA_W-1:0]  host_data_bus_o,
	input wire logic               host_data_bus_oe_o,
	input wire logic [DATA_W-1:0]  event_register_o,
	input wire logic [DATA_W-1:0]  violation_symbol_count_o,
	input wire logic               host_access_error_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////
	sequence sel_edge;
		host_cs_n_i ##1 !host_cs_n_i;
	endsequence
	sequence released;
		!host_cs_n_i ##1 host_cs_n_i [*2];
	endsequence
	////////////////////////////////////////////////////////////
	read_turn_a: assert property (sel_edge ##0 host_direction_i
		|=> !host_data_bus_oe_o ##1 host_data_bus_oe_o) else $error("read drive mistimed");
	write_quiet_a: assert property (sel_edge ##0 !host_direction_i
		|=> !host_data_bus_oe_o [*2]) else $error("bus driven on write");
	read_hold_a: assert property (host_data_bus_oe_o && !host_cs_n_i
		&& !$past(host_cs_n_i) |=> host_data_bus_oe_o [*2]) else $error("hold too short");
	read_float_a: assert property (released |=> !host_data_bus_oe_o)
		else $error("bus not floated");
	data_still_a: assert property (host_data_bus_oe_o && $past(host_data_bus_oe_o)
		|-> $stable(host_data_bus_o)) else $error("read data moved");
	err_cause_a: assert property ($rose(host_access_error_o)
		|-> !$past(host_direction_i, 2) && !$past(host_cs_n_i, 2)) else $error("stray error");
	err_pulse_a: assert property (host_access_error_o
		|=> !host_access_error_o && event_register_o[ACCESS_ERR_BIT]) else $error("bad error");
	count_clear_a: assert property ($rose(host_data_bus_oe_o) && !$past(count_inc_i[0])
		&& $past(register_select_lines_i, 2) == ADDR_CNT_FIRST
		|-> violation_symbol_count_o == WORD_ZERO) else $error("counter kept");
	reset_clear_a: assert property (disable iff (1'b0) !resetn_i |-> !host_data_bus_oe_o
		&& event_register_o == WORD_ZERO) else $error("reset not idle");
endmodule : hrp_port_sva
`default_nettype wire

// file: testbench/hrp_host_model.sv
// processor model running bus cycles on the host register port
`default_nettype none
`timescale 1ns/1ps
module hrp_host_model
	import hrp_pkg::*;
(
	// clock and bus level
	input  wire logic              mclk_i,
	input  wire logic [DATA_W-1:0] bus_i,
	// processor pins
	output var logic               cs_n_o,
	output var logic               dir_o,
	output var logic  [ADDR_W-1:0] addr_o,
	output var logic  [DATA_W-1:0] data_o,
	output var logic               oe_o
);
	initial
	begin
		cs_n_o = 1'b1;
		dir_o = 1'b1;
		addr_o = '0;
		data_o = '0;
		oe_o = 1'b0;
	end
	// one access; ext = extra edges with select low after the start edge
	task automatic acc(input logic rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input int ext, output logic [DATA_W-1:0] q);
		@(posedge mclk_i);
		#1;
		cs_n_o = 1'b0;
		dir_o = rd;
		addr_o = a;
		data_o = d;
		oe_o = !rd;
		@(posedge mclk_i);
		#1;
		addr_o = ~a;
		dir_o = !rd;
		cs_n_o = (ext == 0);
		@(posedge mclk_i);
		#1;
		q = bus_i;
		oe_o = 1'b0;
		repeat (ext > 1 ? ext - 1 : 0)
		begin
			@(posedge mclk_i);
			#1;
		end
		cs_n_o = 1'b1;
		// read: let the device's two-edge hold run out before any new select
		if (rd)
		begin
			@(posedge mclk_i);
			#1;
		end
	endtask : acc
endmodule : hrp_host_model
`default_nettype wire

// file: testbench/host_register_port_tb.sv
// bench for the host register port
`default_nettype none
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t got %h exp %h", $time, (g), (e)); end end
module host_register_port_tb
	import hrp_pkg::*;
;
	typedef struct packed {
		logic              rd;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] e;
		logic [3:0]        ext;
	} hrp_row_t;
	// write rows give the expected error pulse in e
	localparam hrp_row_t ROWS [12] = '{
		'{1'b0, 5'h01, 16'h1234, 16'h0000, 4'h0},
		'{1'b1, 5'h01, 16'h0000, 16'h1234, 4'h0},
		'{1'b1, 5'h01, 16'h0000, 16'h1234, 4'h1},
		'{1'b0, 5'h0D, 16'hFFFF, 16'h0000, 4'h0},
		'{1'b1, 5'h0D, 16'hFFFF, 16'hFFFF, 4'h3},
		'{1'b0, 5'h10, 16'h5555, 16'h0001, 4'h0},
		'{1'b1, 5'h10, 16'h0000, 16'hC3C3, 4'h0},
		'{1'b0, 5'h0E, 16'hAAAA, 16'h0001, 4'h0},
		'{1'b0, 5'h03, 16'hBEEF, 16'h0000, 4'h0},
		'{1'b1, 5'h03, 16'h0000, 16'hBEEF, 4'h2},
		'{1'b1, 5'h17, 16'h0000, 16'h0001, 4'h0},
		'{1'b1, 5'h17, 16'h0000, 16'h0000, 4'h0}};
	logic                      mclk;
	logic                      resetn;
	logic [NUM_CNT-1:0]        cnt_inc;
	logic                      cs_n, dir, h_oe, d_oe, err, pcm_sig, pcm_mnt;
	logic [ADDR_W-1:0]         addr;
	logic [DATA_W-1:0]         h_d, d_d, q, ev, vcnt, sgap, lerr, evs;
	logic [NUM_CFG*DATA_W-1:0] cfg;
	wire  [DATA_W-1:0]         bus;
	int                        n_fail = 0, checks_done = 0, n_err = 0, e0;
	// undriven bus shows the inverse of the host's last word
	assign bus = d_oe ? d_d : (h_oe ? h_d : ~h_d);
	hrp_host_register_port hrp_host_register_port_i (.mclk_i(mclk), .resetn_i(resetn),
		.ce_i(1'b1), .host_cs_n_i(cs_n), .host_direction_i(dir),
		.register_select_lines_i(addr), .host_data_bus_i(bus), .host_data_bus_o(d_d),
		.host_data_bus_oe_o(d_oe), .pcm_signaling_i(pcm_sig), .pcm_maint_i(pcm_mnt),
		.status_words_i({NUM_STAT{16'hC3C3}}), .event_set_i(evs), .count_inc_i(cnt_inc),
		.cfg_words_o(cfg), .event_register_o(ev), .violation_symbol_count_o(vcnt),
		.short_gap_count_o(sgap), .link_error_count_o(lerr), .host_access_error_o(err));
	hrp_host_model hrp_host_model_i (.mclk_i(mclk), .bus_i(bus), .cs_n_o(cs_n), .dir_o(dir),
		.addr_o(addr), .data_o(h_d), .oe_o(h_oe));
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (err === 1'b1)
			n_err++;
	////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("Checks %0d, errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic do_reset();
		resetn = 1'b0;
		repeat (RST_MIN_CYC) @(posedge mclk);
		`CHK({cfg, ev, vcnt}, '0)
		#1;
		resetn = 1'b1;
	endtask : do_reset
	////////////////////////////////////////////////////////////
	initial
	begin
		cnt_inc = '0;
		evs = '0;
		pcm_sig = 1'b0;
		pcm_mnt = 1'b0;
		do_reset();
		foreach (ROWS[k])
		begin
			hrp_host_model_i.acc(ROWS[k].rd, ROWS[k].a, ROWS[k].d, ROWS[k].ext, q);
			if (ROWS[k].rd)
				`CHK(q, ROWS[k].e)
			else
				`CHK({15'h0000, err}, ROWS[k].e)
		end
		// select held low: no second write, one error
		e0 = n_err;
		hrp_host_model_i.acc(1'b0, 5'h1B, 16'h0F0F, 6, q);
		@(posedge mclk);
		`CHK(n_err - e0, 1)
		hrp_host_model_i.acc(1'b1, ADDR_EVENT, 16'h0000, 6, q);
		`CHK(q, WORD_ONE)
		hrp_host_model_i.acc(1'b1, ADDR_EVENT, 16'h0000, 0, q);
		`CHK(q, WORD_ZERO)
		cnt_inc = 3'h7;
		evs = 16'h8000;
		repeat (3) @(posedge mclk);
		#1;
		cnt_inc = '0;
		evs = '0;
		hrp_host_model_i.acc(1'b1, ADDR_CNT_FIRST, 16'h0000, 0, q);
		`CHK({q, vcnt, sgap, lerr}, {16'h0003, WORD_ZERO, 16'h0003, 16'h0003})
		hrp_host_model_i.acc(1'b1, ADDR_EVENT, 16'h0000, 0, q);
		`CHK(q, 16'h8000)
		// restricted registers follow the core's permission levels
		pcm_sig = 1'b1;
		hrp_host_model_i.acc(1'b0, ADDR_VECTOR, 16'h1111, 0, q);
		`CHK(err, 1'b1)
		pcm_sig = 1'b0;
		pcm_mnt = 1'b1;
		hrp_host_model_i.acc(1'b0, ADDR_TPC_LOAD, 16'h2222, 0, q);
		`CHK(err, 1'b0)
		hrp_host_model_i.acc(1'b0, ADDR_CTRL_A, 16'h4000, 0, q);
		hrp_host_model_i.acc(1'b0, ADDR_TNE_LOAD, 16'h3333, 0, q);
		`CHK(err, 1'b1)
		hrp_host_model_i.acc(1'b1, ADDR_VECTOR, 16'h0000, 0, q);
		`CHK(q, 16'hBEEF)
		do_reset();
		hrp_host_model_i.acc(1'b1, 5'h01, 16'h0000, 0, q);
		`CHK(q, WORD_ZERO)
		stop_test();
	end
	initial
	begin
		#50us;
		n_fail++;
		stop_test();
	end
endmodule : host_register_port_tb
bind hrp_host_register_port hrp_port_sva hrp_port_sva_i (.mclk_i, .resetn_i, .host_cs_n_i,
	.host_direction_i, .register_select_lines_i, .count_inc_i, .host_data_bus_o,
	.host_data_bus_oe_o, .event_register_o, .violation_symbol_count_o, .host_access_error_o);
`default_nettype wire
